// file: logic/adc_port_regs.svh
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH
// Summary of operation
// R1: Order low: low byte on lines 7..0.
// R2: Order high: bytes swapped on the bus.
// R3: Format high: result passes as offset binary.
// R4: Format low: invert MSB for two's complement.
// R5: Port select low: results go parallel.
// R6: Port select high: pins become serial port.
// R7: Lines 0,1 driven parallel, hi-z serial.
// R8: Parallel drives bits 2,3 on divider pins.
// R9: Master read-after-convert samples divider pins.
// R10: Other serial modes: divider pins hi-z, ignored.
// R11: Clock source low internal, high external.
// R12: Read mode high during, low after conversion.
// R13: Divider codes give 25/50/100/200 ns periods; code 00 runs at 50 ns, as the half period is never below one cycle.
// R14: Host reads eight lines twice toggling order.

// ****************************************
// Register map
// ****************************************
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define LAST_OFS 8'h08
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1

// ****************************************
// Sizes and timing
// ****************************************
`define RES_W 16
`define FIFO_DEPTH 8
`define CLK_PERIOD_NS 25
`define SCLK_P00_NS 25
`define SCLK_P01_NS 50
`define SCLK_P10_NS 100
`define SCLK_P11_NS 200
`endif

// file: logic/adc_port_pkg.sv
package adc_port_pkg;
   typedef struct packed {
      logic read_mode;
      logic clk_src;
      logic port_sel;
      logic code_fmt;
      logic byte_order;
   } strap_t;

   typedef enum logic {
      ser_idle,
      ser_shift
   } ser_state_t;
endpackage

// file: logic/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic full,
   output logic empty
);
   // Depth must be a power of two; the extra pointer bit tells full from empty.
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW:0] wr_q;
   logic [PW:0] rd_q;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_q[PW-1:0]];

   always_ff @(posedge core_clk) begin
      if (in_valid && !full) begin
         mem[wr_q[PW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
      end else if (in_valid && !full) begin
         wr_q <= wr_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_q <= '0;
      end else if (out_ready && !empty) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule

// file: logic/adc_output_port_format.sv
`timescale 1ns/1ps
`include "adc_port_regs.svh"
module adc_output_port_format #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic res_valid,
   input wire logic [`RES_W-1:0] res_data,
   output logic res_ready,
   input wire logic conv_busy,
   input wire logic byte_order_select,
   input wire logic output_code_format,
   input wire logic port_select,
   input wire logic clock_source_select,
   input wire logic read_mode_or_chain_in,
   input wire logic [1:0] serial_clock_divider,
   input wire logic sclk_i,
   output logic [`RES_W-1:0] data_o,
   output logic [`RES_W-1:0] data_oe,
   output logic sclk_o,
   output logic sclk_oe,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic serial_frame
);
   localparam int W = `RES_W;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [W-1:0] code_fmt(input logic [W-1:0] w, input logic ob);
      code_fmt = {w[W-1] ^ !ob, w[W-2:0]}; // R3 R4
   endfunction

   function automatic logic [W-1:0] byte_order(input logic [W-1:0] w, input logic sw);
      byte_order = sw ? {w[7:0], w[15:8]} : w; // R1 R2
   endfunction

   // Least half period rounds up, never below one cycle.
   function automatic logic [3:0] half_cycles(input int ns);
      int c;
      c = (ns + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS);
      if (c < 1) begin
         c = 1;
      end
      half_cycles = 4'(c);
   endfunction

   localparam logic [3:0] HALF00 = half_cycles(`SCLK_P00_NS);
   localparam logic [3:0] HALF01 = half_cycles(`SCLK_P01_NS);
   localparam logic [3:0] HALF10 = half_cycles(`SCLK_P10_NS);
   localparam logic [3:0] HALF11 = half_cycles(`SCLK_P11_NS);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Straps and pins are asynchronous; a level counts once stages two and three agree.
   logic [7:0] pin_raw;
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;
   logic [7:0] pin_q;
   adc_port_pkg::strap_t strap;
   logic [1:0] div_pin;
   logic sclk_pin;
   logic sclk_prev_q;

   assign pin_raw = {sclk_i, serial_clock_divider, read_mode_or_chain_in, clock_source_select,
                     port_select, output_code_format, byte_order_select};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         pin_q <= 8'h00;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
      end
   end

   assign strap = adc_port_pkg::strap_t'(pin_q[4:0]);
   assign div_pin = pin_q[6:5];
   assign sclk_pin = pin_q[7];

   logic serial_mode;
   logic master;
   logic master_rac;
   logic slave;
   assign serial_mode = strap.port_sel; // R5 R6
   assign master = serial_mode && !strap.clk_src; // R11
   assign slave = serial_mode && strap.clk_src; // R11
   assign master_rac = master && !strap.read_mode; // R9 R12

   // ****************************************
   // Register bus
   // ****************************************
   logic ctrl_en_q;
   logic [W-1:0] last_q;
   logic [1:0] div_q;
   logic f_full;
   logic f_empty;
   adc_port_pkg::ser_state_t ser_state_q;
   logic wr_en;
   logic hit;
   logic [31:0] rd_mux;

   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      if (paddr == `CTRL_OFS) begin
         rd_mux[`CTRL_EN_BIT] = ctrl_en_q;
      end else if (paddr == `STAT_OFS) begin
         rd_mux[9:0] = {ser_state_q == adc_port_pkg::ser_shift, f_empty, f_full, div_q,
                        strap};
      end else if (paddr == `LAST_OFS) begin
         rd_mux[W-1:0] = last_q;
      end else begin
         hit = 1'b0;
      end
   end

   // Read data and error are captured in the setup cycle so they leave flops.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= !hit;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_en_q <= `CTRL_RST;
      end else if (wr_en && paddr == `CTRL_OFS) begin
         ctrl_en_q <= pwdata[`CTRL_EN_BIT];
      end
   end

   // ****************************************
   // Result buffer and formatting
   // ****************************************
   logic f_valid;
   logic f_pop;
   logic [W-1:0] f_data;
   logic [W-1:0] fmt_word;
   logic [W-1:0] par_word;
   logic par_load;
   logic ser_start;

   result_fifo #(
      .W(W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(res_valid),
      .in_data(res_data),
      .in_ready(res_ready),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(f_pop),
      .full(f_full),
      .empty(f_empty)
   );

   assign fmt_word = code_fmt(f_data, strap.code_fmt); // R3 R4
   assign par_word = byte_order(fmt_word, strap.byte_order); // R1 R2
   assign par_load = ctrl_en_q && !serial_mode && f_valid; // R5
   assign f_pop = par_load || ser_start;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_o <= '0;
      end else if (par_load) begin
         data_o <= par_word; // R1 R2 R8
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_q <= '0;
      end else if (f_pop) begin
         last_q <= fmt_word;
      end
   end

   // Whole bus is driven in parallel mode; serial mode turns it round, so the
   // divider pins become inputs only to the sampler below.
   assign data_oe = serial_mode ? '0 : '1; // R7 R8 R10

   // ****************************************
   // Serial port
   // ****************************************
   logic [W-1:0] shreg_q;
   logic [4:0] bit_cnt_q;
   logic [3:0] hcnt_q;
   logic sclk_q;
   logic [3:0] half;
   logic ext_rise;

   always_comb begin
      case (div_q) // R13
         2'b00: half = HALF00;
         2'b01: half = HALF01;
         2'b10: half = HALF10;
         default: half = HALF11;
      endcase
   end

   // Read after convert holds the frame until the converter is idle.
   assign ser_start = ctrl_en_q && serial_mode && f_valid && ser_state_q == adc_port_pkg::ser_idle
                      && (slave || strap.read_mode || !conv_busy); // R12
   assign ext_rise = slave && sclk_pin && !sclk_prev_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_pin;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= 2'b00;
      end else if (ser_start) begin
         div_q <= master_rac ? div_pin : 2'b00; // R9 R10
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ser_state_q <= adc_port_pkg::ser_idle;
         shreg_q <= '0;
         bit_cnt_q <= 5'h00;
         hcnt_q <= 4'h0;
         sclk_q <= 1'b0;
      end else begin
         case (ser_state_q)
            adc_port_pkg::ser_idle: begin
               sclk_q <= 1'b0;
               if (ser_start) begin
                  ser_state_q <= adc_port_pkg::ser_shift;
                  shreg_q <= fmt_word;
                  bit_cnt_q <= 5'(W);
                  hcnt_q <= master_rac ? half_cycles_of(div_pin) : HALF00;
               end
            end
            default: begin
               if (!serial_mode) begin
                  ser_state_q <= adc_port_pkg::ser_idle;
               end else if (master) begin
                  if (hcnt_q == 4'h1) begin
                     hcnt_q <= half; // R13
                     sclk_q <= !sclk_q;
                     if (sclk_q) begin
                        shreg_q <= {shreg_q[W-2:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q - 5'h01;
                        if (bit_cnt_q == 5'h01) begin
                           ser_state_q <= adc_port_pkg::ser_idle;
                        end
                     end
                  end else begin
                     hcnt_q <= hcnt_q - 4'h1;
                  end
               end else if (ext_rise) begin
                  // The chain input follows the local word out of the shifter.
                  shreg_q <= {shreg_q[W-2:0], strap.read_mode};
                  bit_cnt_q <= bit_cnt_q - 5'h01;
                  if (bit_cnt_q == 5'h01) begin
                     ser_state_q <= adc_port_pkg::ser_idle;
                  end
               end
            end
         endcase
      end
   end

   function automatic logic [3:0] half_cycles_of(input logic [1:0] code);
      case (code)
         2'b00: half_cycles_of = HALF00;
         2'b01: half_cycles_of = HALF01;
         2'b10: half_cycles_of = HALF10;
         default: half_cycles_of = HALF11;
      endcase
   endfunction

   assign sclk_o = sclk_q;
   assign sclk_oe = master; // R11
   assign serial_result_out = shreg_q[W-1];
   assign serial_result_oe = serial_mode; // R6
   assign serial_frame = (ser_state_q == adc_port_pkg::ser_shift);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_par_take;
      par_load && !serial_mode;
   endsequence

   sequence s_master_start;
      ser_start && master;
   endsequence

   chk_order_low: assert property ((s_par_take and !strap.byte_order) |=> data_o == $past(fmt_word)) // R1
      else $error("low byte not on low lines");
   chk_order_swap: assert property ((s_par_take and strap.byte_order)
      |=> data_o == {$past(fmt_word[7:0]), $past(fmt_word[15:8])}) // R2
      else $error("bytes not swapped");
   chk_binary_pass: assert property (f_valid && strap.code_fmt |-> fmt_word == f_data) // R3
      else $error("offset binary altered");
   chk_twos_msb: assert property (f_valid && !strap.code_fmt
      |-> fmt_word == {!f_data[W-1], f_data[W-2:0]}) // R4
      else $error("msb not inverted");
   chk_parallel_drive: assert property (!serial_mode |-> data_oe == '1 && !serial_result_oe) // R5
      else $error("parallel bus not driven");
   chk_low_lines_hiz: assert property (serial_mode |-> data_oe[1:0] == 2'b00) // R7
      else $error("lines 0 and 1 driven in serial");
   chk_div_pins_hiz: assert property (serial_mode && !master_rac |-> data_oe[3:2] == 2'b00) // R10
      else $error("divider pins driven");
   chk_div_sample: assert property ((s_master_start and !strap.read_mode)
      |=> div_q == $past(div_pin)) // R9
      else $error("divider not sampled");
   chk_clk_source: assert property (serial_mode |-> sclk_oe == !strap.clk_src) // R11
      else $error("serial clock source wrong");
   chk_rac_wait: assert property (s_master_start |-> strap.read_mode || !conv_busy) // R12
      else $error("frame started during conversion");
   chk_slow_period: assert property (master && div_q == 2'b11 && $rose(sclk_q)
      |-> sclk_q [*4]) // R13
      else $error("slow clock high phase wrong");
endmodule

// file: dv/result_host.sv
`timescale 1ns/1ps
// ****************************************
// Serial result receiver
// ****************************************
// Bits are taken only on a rising serial clock, so a clock phase slip shows up as a wrong word.
module result_host (
   input wire logic core_clk,
   input wire logic sclk_o,
   input wire logic serial_result_out,
   input wire logic serial_frame,
   output logic [15:0] word,
   output int period,
   output int words
);
   logic sclk_prev;
   logic [15:0] shreg;
   int bits;
   int cyc;
   initial begin
      sclk_prev = 1'b0;
      shreg = 16'h0000;
      bits = 0;
      cyc = 0;
      word = 16'h0000;
      period = 0;
      words = 0;
   end
   always @(posedge core_clk) begin
      sclk_prev <= sclk_o;
      cyc <= cyc + 1;
      if (!serial_frame) begin
         bits <= 0;
      end else if (sclk_o && !sclk_prev) begin
         shreg <= {shreg[14:0], serial_result_out};
         period <= cyc;
         cyc <= 1;
         bits <= bits + 1;
         if (bits == 15) begin
            word <= {shreg[14:0], serial_result_out};
            words <= words + 1;
         end
      end
   end
endmodule

// file: dv/test_adc_output_port_format.sv
`timescale 1ns/1ps
module test_adc_output_port_format;
   typedef struct packed {
      logic order;
      logic fmt;
      logic [15:0] raw;
      logic [15:0] exp;
      logic [15:0] last;
   } row_t;
   row_t rows [4] = '{
      '{1'b0, 1'b1, 16'h1234, 16'h1234, 16'h1234},
      '{1'b0, 1'b0, 16'h1234, 16'h9234, 16'h9234},
      '{1'b1, 1'b1, 16'h8001, 16'h0180, 16'h8001},
      '{1'b1, 1'b0, 16'h8001, 16'h0100, 16'h0001}};
   logic [1:0] sdiv [3] = '{2'b10, 2'b11, 2'b11};
   logic srm [3] = '{1'b0, 1'b0, 1'b1};
   int sper [3] = '{4, 8, 2};
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic res_valid, res_ready, conv_busy, er;
   logic [15:0] res_data, data_o, data_oe, host_pins, pins, hword;
   logic byte_order_select, output_code_format, port_select, sclk_i;
   logic sclk_o, sclk_oe, serial_result_out, serial_result_oe, serial_frame;
   int fails, compares, words, period, base;

   // The shared data pins carry whichever side drives them.
   assign pins = (data_o & data_oe) | (host_pins & ~data_oe);

   adc_output_port_format adc_output_port_format_inst (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .res_valid(res_valid),
      .res_data(res_data), .res_ready(res_ready), .conv_busy(conv_busy),
      .byte_order_select(byte_order_select), .output_code_format(output_code_format),
      .port_select(port_select), .clock_source_select(pins[4]),
      .read_mode_or_chain_in(pins[7]), .serial_clock_divider(pins[3:2]), .sclk_i(sclk_i),
      .data_o(data_o), .data_oe(data_oe), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
      .serial_frame(serial_frame));
   result_host result_host_inst (.core_clk(core_clk), .sclk_o(sclk_o),
      .serial_result_out(serial_result_out), .serial_frame(serial_frame), .word(hword),
      .period(period), .words(words));

   always #12.5 core_clk = ~core_clk;

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic push(input logic [15:0] w);
      @(posedge core_clk);
      res_valid <= 1'b1;
      res_data <= w;
      @(posedge core_clk);
      res_valid <= 1'b0;
   endtask

   task automatic wait_words(input int n);
      int k;
      k = 0;
      while (words < n && k < 3000) begin
         @(posedge core_clk);
         k++;
      end
      if (words < n) begin
         fails++;
         $display("unexpected words expected %0d seen %0d", n, words);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      stop_test();
   end

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, res_valid, conv_busy, sclk_i} = 6'h00;
      {byte_order_select, output_code_format, port_select} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      res_data = 16'h0000;
      host_pins = 16'h0000;
      fails = 0;
      compares = 0;
      repeat (6) @(posedge core_clk);
      check("reset_oe", 32'hffff, 32'(data_oe));
      check("reset_ready", 32'h1, 32'(res_ready));
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl_reset", 32'h1, rd);
      apb(1'b0, 8'h0c, 32'h0);
      check("unmapped_err", 32'h1, 32'(er));
      check("unmapped_data", 32'h0, rd);
      // ****************************************
      // Parallel formats and byte orders
      // ****************************************
      foreach (rows[i]) begin
         @(posedge core_clk);
         byte_order_select <= rows[i].order;
         output_code_format <= rows[i].fmt;
         repeat (6) @(posedge core_clk);
         push(rows[i].raw);
         repeat (3) @(posedge core_clk);
         check("data_o", 32'(rows[i].exp), 32'(data_o));
         check("data_oe", 32'hffff, 32'(data_oe));
         apb(1'b0, 8'h08, 32'h0);
         check("last", 32'(rows[i].last), rd);
      end
      // An eight-line host reads the low lines twice, flipping the order between reads.
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         byte_order_select <= 1'(k);
         output_code_format <= 1'b1;
         repeat (6) @(posedge core_clk);
         push(16'hab12);
         repeat (3) @(posedge core_clk);
         check("byte_read", (k == 0) ? 32'h12 : 32'hab, 32'(pins[7:0]));
      end
      // ****************************************
      // Serial master clock rates
      // ****************************************
      @(posedge core_clk);
      byte_order_select <= 1'b0;
      output_code_format <= 1'b1;
      port_select <= 1'b1;
      foreach (sdiv[i]) begin
         @(posedge core_clk);
         host_pins[3:2] <= sdiv[i];
         host_pins[7] <= srm[i];
         repeat (6) @(posedge core_clk);
         base = words;
         push(16'hc5a3);
         wait_words(base + 1);
         check("serial_word", 32'hc5a3, 32'(hword));
         check("sclk_period", 32'(sper[i]), 32'(period));
         check("serial_oe", 32'h0, 32'(data_oe));
         check("sclk_oe_int", 32'h1, 32'(sclk_oe));
         check("sdo_oe", 32'h1, 32'(serial_result_oe));
      end
      // Read after convert must hold the frame back while the converter is busy.
      @(posedge core_clk);
      host_pins[7] <= 1'b0;
      conv_busy <= 1'b1;
      repeat (6) @(posedge core_clk);
      base = words;
      push(16'h3c96);
      repeat (40) @(posedge core_clk);
      check("busy_hold", 32'(base), 32'(words));
      check("busy_frame", 32'h0, 32'(serial_frame));
      conv_busy <= 1'b0;
      wait_words(base + 1);
      check("after_busy", 32'h3c96, 32'(hword));
      check("rac_period", 32'h8, 32'(period));
      @(posedge core_clk);
      host_pins[4] <= 1'b1;
      repeat (6) @(posedge core_clk);
      check("sclk_oe_ext", 32'h0, 32'(sclk_oe));
      @(posedge core_clk);
      host_pins[4] <= 1'b0;
      // ****************************************
      // Buffer filled to refusal, then drained
      // ****************************************
      apb(1'b1, 8'h00, 32'h0);
      base = words;
      for (int i = 0; i < 8; i++) begin
         push(16'(i));
      end
      @(posedge core_clk);
      check("full_ready", 32'h0, 32'(res_ready));
      apb(1'b0, 8'h04, 32'h0);
      check("stat_full", 32'h1, 32'(rd[7]));
      apb(1'b1, 8'h00, 32'h1);
      wait_words(base + 8);
      check("drained", 32'(base + 8), 32'(words));
      check("last_serial", 32'h0007, 32'(hword));
      apb(1'b0, 8'h04, 32'h0);
      check("stat_empty", 32'h1, 32'(rd[8]));
      stop_test();
   end
endmodule
